// File: common/rtr_pkg.sv
// Purpose: Types for the clock register and SRAM space
// Assumes: Nothing beyond the constants header
// Notes: Time snapshot travels as one packed struct
package rtr_pkg;
	typedef enum logic [1:0] {RTR_CMD, RTR_ADDR, RTR_WDATA, RTR_RDATA} rtr_phase_t;
	typedef struct packed {
		logic [7:0] minutes;
		logic [7:0] hours;
		logic [7:0] date;
		logic [7:0] month;
	} rtr_time_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} rtr_wr_t;
endpackage

// File: common/rtr_regs.svh
// Purpose: Named constants for the clock register and SRAM space
// Assumes: Byte addresses on an eight-bit serial address
// Notes: Instruction codes are parameters of the top module
`ifndef RTR_REGS_SVH
`define RTR_REGS_SVH
`define RTR_RTC_FIRST 8'h00
`define RTR_RTC_LAST 8'h1F
`define RTR_RAM_FIRST 8'h20
`define RTR_RAM_LAST 8'h5F
`define RTR_PD_MIN 8'h18
`define RTR_PD_HOUR 8'h19
`define RTR_PD_DATE 8'h1A
`define RTR_PD_MONTH 8'h1B
`define RTR_PU_MIN 8'h1C
`define RTR_PU_HOUR 8'h1D
`define RTR_PU_DATE 8'h1E
`define RTR_PU_MONTH 8'h1F
`define RTR_DAY_OF_WEEK_CODE 8'h03
`define RTR_MIN_MASK 8'h7F
`define RTR_HOUR_MASK 8'h7F
`define RTR_DATE_MASK 8'h3F
`define RTR_MONTH_MASK 8'hFF
`define RTR_DAY_OF_WEEK_CODE_MASK 8'h1F
`define RTR_FAIL_BIT 4
`define RTR_VBEN_BIT 3
`define RTR_OSC_BIT 5
`define RTR_STAMP_RESET 8'h00
`define RTR_BYTE_LAST 3'h7
`define RTR_PIN_IDLE 3'h4
`endif

// File: rtl/rtr_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Ready on the filling side falls only when both slots hold data
`timescale 1ns/1ps
module rtr_buf2 #(
	parameter int WIDTH = 16
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] slot_reg [2];
	logic [WIDTH-1:0] slot_next [2];
	logic [1:0] cnt_reg, cnt_next;
	logic rd_reg, rd_next;
	logic wr_reg, wr_next;

	// Handshakes follow the fill count
	assign in_ready = (cnt_reg != 2'h2);
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data = slot_reg[rd_reg];

	// Pointer and count update
	always_comb begin
		logic push;
		logic pop;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		slot_next[0] = slot_reg[0];
		slot_next[1] = slot_reg[1];
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (push) begin
			slot_next[wr_reg] = in_data;
			wr_next = ~wr_reg;
		end
		if (pop) begin
			rd_next = ~rd_reg;
		end
		if (push && !pop) begin
			cnt_next = cnt_reg + 2'h1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 2'h1;
		end
	end

	// Storage holds no reset; pointers do
	always_ff @(posedge mclk) begin
		slot_reg <= slot_next;
		if (sys_rst) begin
			cnt_reg <= 2'h0;
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			rd_reg <= rd_next;
			wr_reg <= wr_next;
		end
	end
endmodule

// File: rtl/rtr_space.sv
// Purpose: Serial-accessed timekeeping registers and 64-byte SRAM
// Assumes: Serial mode 0, MSB first; link pins are asynchronous to mclk
// Notes: Counters, alarms and nonvolatile memory live elsewhere
// Behaviour
// RULE1 - Stamp date: BCD day, bits 7-6 zero
// RULE2 - Stamp month bits 7-5 hold weekday code
// RULE3 - Stamp month: BCD month, tens in bit 4
// RULE4 - Stamps at 1A/1B and 1E/1F
// RULE5 - Clock regs 00-1F, SRAM 20-5F
// RULE6 - SRAM access never stalls during updates
// RULE7 - SRAM not cleared by reset
// RULE8 - No serial access on backup supply
// RULE9 - Host sends select, write code, address, data
// RULE10 - Unlimited data bytes, pointer advances each
// RULE11 - Pointer wraps inside its region
// RULE12 - Byte committed at its eighth bit
// RULE13 - Host raises select to end write
// RULE14 - Access allowed during nonvolatile write cycle
// RULE15 - Same read/write codes for both regions
// RULE16 - SRAM kept over primary loss with backup
// RULE17 - Power events copy time, set fail flag
// RULE18 - No capture while fail flag set; a flag-clearing write in the same cycle still lets a capture through
// RULE19 - Clearing fail flag zeroes all stamps
// RULE20 - Reads advance pointer with same wrap
// RULE21 - Unused bits and out-of-range writes dropped
// RULE22 - Partial final byte discarded
`timescale 1ns/1ps
`include "rtr_regs.svh"
module rtr_space
	import rtr_pkg::*;
#(
	parameter logic [7:0] WRITE_CODE = 8'h12,
	parameter logic [7:0] READ_CODE = 8'h13
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	input wire logic on_backup,
	input wire logic power_lost_evt,
	input wire logic power_back_evt,
	input wire logic [31:0] time_now,
	input wire logic osc_running,
	input wire logic nv_write_busy,
	output logic power_fail_flag,
	output logic backup_input_enable
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] sy1_reg, sy2_reg;
	logic sck_d_reg;
	logic sck_s, cs_s, si_s, sck_rise, sck_fall;

	// Two flops per pin; only the second is read
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			// Idle pin levels {select high, clock low, data low}: no false edge
			sy1_reg <= `RTR_PIN_IDLE;
			sy2_reg <= `RTR_PIN_IDLE;
			sck_d_reg <= 1'b0;
		end else begin
			sy1_reg <= {cs_n, sck, si};
			sy2_reg <= sy1_reg;
			sck_d_reg <= sy2_reg[1];
		end
	end
	assign cs_s = sy2_reg[2];
	assign sck_s = sy2_reg[1];
	assign si_s = sy2_reg[0];
	assign sck_rise = sck_s && !sck_d_reg;
	assign sck_fall = !sck_s && sck_d_reg;

	// ------------------------------------------------------------
	// Serial command engine
	// ------------------------------------------------------------
	rtr_phase_t phase_reg, phase_next;
	logic [2:0] bit_reg, bit_next;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] ptr_reg, ptr_next;
	logic [7:0] tx_reg, tx_next;
	logic live_reg, live_next;
	logic oe_reg, oe_next;
	logic wr_valid;
	logic wr_ready;
	rtr_wr_t wr_word;
	logic [7:0] rx_byte;

	assign rx_byte = {sh_reg[6:0], si_s};

	// Wrap within the region the pointer sits in
	function automatic logic [7:0] rtr_step(input logic [7:0] a);
		logic [7:0] n;
		n = a + 8'h01;
		if (a == `RTR_RTC_LAST) begin
			n = `RTR_RTC_FIRST; // RULE11 RULE20
		end else if (a == `RTR_RAM_LAST) begin
			n = `RTR_RAM_FIRST; // RULE11 RULE20
		end
		return n;
	endfunction

	// Shift, decode and pointer state
	always_comb begin
		phase_next = phase_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		ptr_next = ptr_reg;
		tx_next = tx_reg;
		live_next = live_reg;
		oe_next = oe_reg;
		wr_valid = 1'b0;
		if (cs_s || on_backup) begin
			// Deselect drops a partial byte; backup blocks the link
			phase_next = RTR_CMD; // RULE22 RULE8 RULE13
			bit_next = 3'h0;
			live_next = !on_backup;
			oe_next = 1'b0;
		end else if (!live_reg) begin
			oe_next = 1'b0; // RULE8
		end else if (sck_rise) begin
			sh_next = rx_byte;
			bit_next = bit_reg + 3'h1;
			if (bit_reg == `RTR_BYTE_LAST) begin
				case (phase_reg)
					RTR_CMD: begin
						// One code pair serves both regions
						if (rx_byte == WRITE_CODE) begin
							phase_next = RTR_ADDR; // RULE15 RULE9
						end else if (rx_byte == READ_CODE) begin
							phase_next = RTR_ADDR; // RULE15
							oe_next = 1'b1;
						end else begin
							live_next = 1'b0; // Other codes belong elsewhere
						end
					end
					RTR_ADDR: begin
						// First read byte waits for the falling edge, so out holds while high
						ptr_next = rx_byte;
						phase_next = oe_reg ? RTR_RDATA : RTR_WDATA;
					end
					RTR_WDATA: begin
						wr_valid = 1'b1; // RULE12 RULE10
						ptr_next = rtr_step(ptr_reg); // RULE10
					end
					default: begin
						ptr_next = rtr_step(ptr_reg); // RULE20
					end
				endcase
			end
		end else if (sck_fall && phase_reg == RTR_RDATA) begin
			if (bit_reg == 3'h0) begin
				tx_next = rtr_rd(ptr_reg);
			end else begin
				tx_next = {tx_reg[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			phase_reg <= RTR_CMD;
			bit_reg <= 3'h0;
			sh_reg <= 8'h00;
			ptr_reg <= 8'h00;
			tx_reg <= 8'h00;
			live_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			ptr_reg <= ptr_next;
			tx_reg <= tx_next;
			live_reg <= live_next;
			oe_reg <= oe_next;
		end
	end
	assign so = tx_reg[7];
	assign so_oe = oe_reg && phase_reg == RTR_RDATA;
	assign wr_word = '{addr: ptr_reg, data: rx_byte};

	// ------------------------------------------------------------
	// Write buffer and storage
	// ------------------------------------------------------------
	rtr_wr_t bw;
	logic bw_valid;

	// Buffer hands each commit to storage; its output is always ready, so it never holds back
	rtr_buf2 #(.WIDTH(16)) u_buf (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_word),
		.out_valid(bw_valid),
		.out_ready(1'b1),
		.out_data(bw)
	);

	logic [7:0] ram [64];
	logic [7:0] wk_reg, wk_next;
	rtr_time_t pd_reg, pd_next, pu_reg, pu_next;

	// Read mux: stamp fields and weekday flags, SRAM, zero elsewhere
	function automatic logic [7:0] rtr_rd(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a == `RTR_PD_MIN) begin
			r = pd_reg.minutes;
		end else if (a == `RTR_PD_HOUR) begin
			r = pd_reg.hours;
		end else if (a == `RTR_PD_DATE) begin
			r = pd_reg.date; // RULE4 RULE1
		end else if (a == `RTR_PD_MONTH) begin
			r = pd_reg.month; // RULE4 RULE2 RULE3
		end else if (a == `RTR_PU_MIN) begin
			r = pu_reg.minutes;
		end else if (a == `RTR_PU_HOUR) begin
			r = pu_reg.hours;
		end else if (a == `RTR_PU_DATE) begin
			r = pu_reg.date; // RULE4
		end else if (a == `RTR_PU_MONTH) begin
			r = pu_reg.month; // RULE4
		end else if (a == `RTR_DAY_OF_WEEK_CODE) begin
			r = wk_reg;
			r[`RTR_OSC_BIT] = osc_running;
		end else if (a >= `RTR_RAM_FIRST && a <= `RTR_RAM_LAST) begin
			r = ram[a[5:0]]; // RULE5 RULE6
		end
		return r;
	endfunction

	// Masked field updates; captures, writes and flag clears
	always_comb begin
		logic [7:0] d;
		rtr_time_t snap;
		logic clr;
		clr = 1'b0;
		d = bw.data;
		snap = time_now;
		snap.date = snap.date & `RTR_DATE_MASK; // RULE1
		snap.month = {wk_reg[2:0], snap.month[4:0]}; // RULE2 RULE3
		pd_next = pd_reg;
		pu_next = pu_reg;
		wk_next = wk_reg;
		if (bw_valid) begin
			if (bw.addr == `RTR_PD_MIN) pd_next.minutes = d & `RTR_MIN_MASK; // RULE21
			else if (bw.addr == `RTR_PD_HOUR) pd_next.hours = d & `RTR_HOUR_MASK;
			else if (bw.addr == `RTR_PD_DATE) pd_next.date = d & `RTR_DATE_MASK; // RULE1
			else if (bw.addr == `RTR_PD_MONTH) pd_next.month = d & `RTR_MONTH_MASK;
			else if (bw.addr == `RTR_PU_MIN) pu_next.minutes = d & `RTR_MIN_MASK;
			else if (bw.addr == `RTR_PU_HOUR) pu_next.hours = d & `RTR_HOUR_MASK;
			else if (bw.addr == `RTR_PU_DATE) pu_next.date = d & `RTR_DATE_MASK;
			else if (bw.addr == `RTR_PU_MONTH) pu_next.month = d & `RTR_MONTH_MASK;
			else if (bw.addr == `RTR_DAY_OF_WEEK_CODE) begin
				wk_next = d & `RTR_DAY_OF_WEEK_CODE_MASK;
				// Fail flag is set-only by hardware; software may only clear
				wk_next[`RTR_FAIL_BIT] = wk_reg[`RTR_FAIL_BIT] & d[`RTR_FAIL_BIT];
				if (wk_reg[`RTR_FAIL_BIT] && !d[`RTR_FAIL_BIT]) begin
					clr = 1'b1;
					pd_next = '0; // RULE19
					pu_next = '0; // RULE19
				end
			end
		end
		// Capture only while flag clear; a capture beats a same-cycle clear
		if ((power_lost_evt || power_back_evt) && (!wk_reg[`RTR_FAIL_BIT] || clr)) begin // RULE18
			if (power_lost_evt) pd_next = snap; // RULE17
			if (power_back_evt) pu_next = snap; // RULE17
			wk_next[`RTR_FAIL_BIT] = 1'b1; // RULE17
		end
	end

	// Stamps reset to zero; SRAM has no reset and keeps its bytes
	always_ff @(posedge mclk) begin
		if (bw_valid && bw.addr >= `RTR_RAM_FIRST && bw.addr <= `RTR_RAM_LAST) begin
			ram[bw.addr[5:0]] <= bw.data; // RULE7 RULE16 RULE6 RULE14 RULE21
		end
		if (sys_rst) begin
			pd_reg <= {4{`RTR_STAMP_RESET}};
			pu_reg <= {4{`RTR_STAMP_RESET}};
			wk_reg <= 8'h00;
		end else begin
			pd_reg <= pd_next;
			pu_reg <= pu_next;
			wk_reg <= wk_next;
		end
	end
	assign power_fail_flag = wk_reg[`RTR_FAIL_BIT];
	assign backup_input_enable = wk_reg[`RTR_VBEN_BIT];
endmodule

// File: sim/rtr_host.sv
// Purpose: Serial host that talks to the register space
// Assumes: Mode 0, MSB first, 48 ns link period
// Notes: Link clock stands low between frames
`timescale 1ns/1ps
module rtr_host (
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	// --------
	// Link idle
	// --------
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// Select first, then code, address and data follow
	task automatic sel();
		cs_n = 1'b0;
		#24;
	endtask
	// Released data line shows the inverse, not the last bit
	task automatic desel();
		#24 cs_n = 1'b1;
		si = ~si;
		#200;
	endtask
	// Fewer than eight bits leaves a partial byte
	task automatic xb(input logic [7:0] t, input int n, output logic [7:0] r);
		r = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			si = t[i];
			#24 sck = 1'b1;
			r[i] = so;
			#24 sck = 1'b0;
		end
	endtask
endmodule

// File: sim/rtr_space_asserts.sv
// Purpose: Port checks for the register space
// Assumes: One mclk domain, reset synchronous active high
// Notes: Serial pins pass a two-flop synchroniser, hence the margins
`timescale 1ns/1ps
module rtr_space_asserts (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic so,
	input wire logic so_oe,
	input wire logic on_backup,
	input wire logic power_lost_evt,
	input wire logic power_back_evt,
	input wire logic power_fail_flag,
	input wire logic backup_input_enable
);
	// --------
	// Checks
	// --------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	a_reset_clear: assert property ($fell(sys_rst) |-> !power_fail_flag && !so_oe)
		else $error("outputs not clear after reset");
	a_idle_quiet: assert property (cs_n [*4] |-> !so_oe)
		else $error("serial out driven while deselected");
	a_backup_quiet: assert property (on_backup [*8] |-> !so_oe)
		else $error("serial out driven on backup supply");
	a_lost_flag: assert property (power_lost_evt |-> ##[1:3] power_fail_flag)
		else $error("power loss did not set flag");
	a_back_flag: assert property (power_back_evt |-> ##[1:3] power_fail_flag)
		else $error("power return did not set flag");
	// Flag may only fall through a completed serial write
	a_flag_keep: assert property (cs_n [*8] ##0 power_fail_flag |=> power_fail_flag)
		else $error("flag dropped without a write");
	a_flag_noset: assert property ((!power_lost_evt && !power_back_evt) [*4] ##0 !power_fail_flag
		|=> !power_fail_flag)
		else $error("flag set without a power event");
	// Output bit moves on the falling link edge only
	a_so_steady: assert property ((sck && !cs_n) [*4] |-> $stable(so))
		else $error("serial out moved while link clock high");
	c_lost: cover property (power_lost_evt ##[1:3] power_fail_flag);
	c_read: cover property ($rose(so_oe));
	c_backup: cover property (on_backup && !cs_n);
endmodule
bind rtr_space rtr_space_asserts chk (.mclk(mclk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n),
	.so(so), .so_oe(so_oe), .on_backup(on_backup), .power_lost_evt(power_lost_evt),
	.power_back_evt(power_back_evt), .power_fail_flag(power_fail_flag),
	.backup_input_enable(backup_input_enable));

// File: sim/tb.sv
// Purpose: Self-checking bench for the register space
// Assumes: Default write and read codes
// Notes: Host model drives the link pins
`timescale 1ns/1ps
`include "rtr_regs.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module tb
	import rtr_pkg::*;
;
	logic mclk, sys_rst, sck, cs_n, si, so, so_oe, on_backup, lost, back, osc, nvb, flag, ven;
	logic [31:0] time_now;
	int n_errors, checks_done;
	rtr_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
	rtr_space dut (.mclk(mclk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si),
		.so(so), .so_oe(so_oe), .on_backup(on_backup), .power_lost_evt(lost),
		.power_back_evt(back), .time_now(time_now), .osc_running(osc),
		.nv_write_busy(nvb), .power_fail_flag(flag), .backup_input_enable(ven));
	always #2.5 mclk = ~mclk;
	// --------
	// Bus tasks
	// --------
	task automatic cmd(input logic [7:0] c, input logic [7:0] a);
		logic [7:0] r;
		host.sel();
		host.xb(c, 8, r);
		host.xb(a, 8, r);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
		logic [7:0] r;
		cmd(8'h12, a);
		foreach (d[i]) host.xb(d[i], 8, r);
		host.desel();
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e[$]);
		logic [7:0] r;
		cmd(8'h13, a);
		foreach (e[i]) begin
			host.xb(8'hFF, 8, r);
			`CHK(nm, e[i], r)
		end
		`CHK("drive", 1'b1, so_oe)
		host.desel();
		`CHK("so_oe", 1'b0, so_oe)
	endtask
	task automatic ev(input logic dn);
		@(negedge mclk);
		{lost, back} = {dn, !dn};
		@(negedge mclk);
		{lost, back} = 2'h0;
		repeat (4) @(negedge mclk);
	endtask
	// --------
	// Scenarios
	// --------
	task automatic t_map();
		rd("stamps", `RTR_PD_MIN, '{8{8'h00}});
		wr(`RTR_PD_DATE, '{8'hFF, 8'hFF});
		rd("fields", `RTR_PD_DATE, '{8'h3F, 8'hFF});
		wr(8'h5E, '{8'hA1, 8'hA2, 8'hA3});
		rd("wrap", 8'h5E, '{8'hA1, 8'hA2, 8'hA3});
		wr(8'h60, '{8'h5A});
		rd("range", `RTR_RAM_FIRST, '{8'hA3});
	endtask
	task automatic t_cut();
		logic [7:0] r;
		cmd(8'h12, 8'h21);
		host.xb(8'h3C, 8, r);
		host.xb(8'hC3, 5, r);
		host.desel();
		rd("partial", 8'h21, '{8'h3C});
		cmd(8'h05, 8'h21);
		host.xb(8'h77, 8, r);
		host.desel();
		rd("foreign", 8'h21, '{8'h3C});
		on_backup = 1'b1;
		wr(8'h21, '{8'h99});
		on_backup = 1'b0;
		rd("backup", 8'h21, '{8'h3C});
	endtask
	task automatic t_power();
		time_now = 32'h4512_3112;
		wr(`RTR_DAY_OF_WEEK_CODE, '{8'h0B});
		`CHK("enable", 1'b1, ven)
		ev(1'b1);
		`CHK("flag", 1'b1, flag)
		rd("day_of_week_code", `RTR_DAY_OF_WEEK_CODE, '{8'h3B});
		time_now = 32'h5923_0101;
		ev(1'b1);
		rd("down", `RTR_PD_MIN, '{8'h45, 8'h12, 8'h31, 8'h72});
		wr(`RTR_DAY_OF_WEEK_CODE, '{8'h0B});
		`CHK("clear", 1'b0, flag)
		rd("zero", `RTR_PD_MIN, '{8{8'h00}});
		ev(1'b0);
		rd("up", `RTR_PU_DATE, '{8'h01, 8'h61});
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Main sequence; busy nonvolatile write must not block access
	initial begin
		{mclk, sys_rst, on_backup, lost, back, osc, nvb} = 7'h63;
		time_now = 32'h0;
		repeat (16) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (4) @(negedge mclk);
		t_map();
		t_cut();
		t_power();
		test_done();
	end
	// Watchdog well past the expected run
	initial begin
		#300000;
		n_errors++;
		test_done();
	end
endmodule
